/* File: rtl/pamw_pkg.sv */
// Constants for the port A pin mux and wakeup block
package pamw_pkg;
    localparam logic [7:0] ADDR_PORT_OUT  = 8'h00;
    localparam logic [7:0] ADDR_PORT_OE   = 8'h04;
    localparam logic [7:0] ADDR_PORT_IN   = 8'h08;
    localparam logic [7:0] ADDR_FUNC_CFG  = 8'h0c;
    localparam logic [7:0] ADDR_IF_CFG    = 8'h10;
    localparam logic [7:0] ADDR_FIFO_POL  = 8'h14;
    localparam logic [7:0] ADDR_WAKE_CTL  = 8'h18;
    localparam logic [7:0] ADDR_CORE_CTL  = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h24;
    localparam logic [7:0] ADDR_STATUS    = 8'h28;

    localparam int WAKE_POL_BIT    = 4;
    localparam int WAKE_EN2_BIT    = 1;
    localparam int WAKE_PA3FN_BIT  = 7;
    localparam int OE_PA3_BIT      = 3;
    localparam int FIFO_OE_POL_BIT = 4;
    localparam int CORE_IT0_BIT    = 0;
    localparam int CORE_IT1_BIT    = 1;
    localparam int CORE_FLASH_BIT  = 2;
    localparam int CORE_SUSP_BIT   = 3;

    localparam int IRQ_WAKE1 = 0;
    localparam int IRQ_WAKE2 = 1;
    localparam int IRQ_EXTA  = 2;
    localparam int IRQ_EXTB  = 3;
    localparam int IRQ_NUM   = 4;

    localparam logic [1:0] IFMODE_SLAVE_FIFO = 2'h3;
    localparam logic [5:0] OE_RESET = 6'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        PAMW_RUN,
        PAMW_SUSPENDED
    } pamw_power_t;
endpackage

/* File: rtl/pamw_top.sv */
// Port A pin mux and wakeup logic with AHB-Lite register slave
// How it works
// - While suspended, asserted resume pin restarts oscillator and raises interrupt.
// - Suspend request refused while resume pin is asserted.
// - Resume pin asserted level set by wakeup control bit 4.
// - Function config bits 0 and 1 pick port bit or ext irq.
// - Ext irq a is active low; trigger bit 1 edge, 0 level.
// - Ext irq b is active low; trigger bit 1 edge, 0 level.
// - Interface mode bits 1:0 pick functions of pins 2, 4, 5.
// - Slave FIFO mode: pin 2 is input FIFO output enable, polarity bit 4.
// - Pin 3 function from wakeup bit 7 and output enable bit 3.
// - Enabled second resume blocks suspend while pin 3 asserted.
// - Flash mode: pin 0 drives command latch, pin 1 address latch.
// - Flash mode: pin 4 drives flash write protect, active low.
// - Flash mode: pins 2, 3 sink data and chip activity lamps.
module pamw_top
    import pamw_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        resume_pin,
    input  wire logic [5:0]  porta_in,
    output logic      [5:0]  porta_out,
    output logic      [5:0]  porta_oe,
    input  wire logic        flash_cmd_latch,
    input  wire logic        flash_addr_latch,
    input  wire logic        data_activity,
    input  wire logic        chip_activity,
    input  wire logic        flash_protect,
    output logic             write_protect_switch_n,
    output logic             fifo_output_enable_in,
    output logic      [1:0]  fifo_select,
    output logic             osc_run,
    output logic             suspended,
    output logic             ext_irq_a,
    output logic             ext_irq_b,
    output logic             irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [5:0]         port_out_reg;
    logic [5:0]         porta_output_enable;
    logic [1:0]         porta_function_cfg;
    logic [1:0]         interface_cfg;
    logic [7:0]         fifo_pin_polarity;
    logic [7:0]         wake_ctl;
    logic [3:0]         core_ctl;
    logic [IRQ_NUM-1:0] irq_stat;
    logic [IRQ_NUM-1:0] irq_mask;
    logic [5:0]         pin_q;
    logic               pa3_q;
    pamw_power_t        power;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic       ph_wr;
    logic [7:0] ph_addr;
    wire        ap_valid = hsel && htrans[1] && hready;
    wire        wr_now   = ph_wr;
    wire        wr_out   = wr_now && ph_addr == ADDR_PORT_OUT;
    wire        wr_oe    = wr_now && ph_addr == ADDR_PORT_OE;
    wire        wr_func  = wr_now && ph_addr == ADDR_FUNC_CFG;
    wire        wr_if    = wr_now && ph_addr == ADDR_IF_CFG;
    wire        wr_pol   = wr_now && ph_addr == ADDR_FIFO_POL;
    wire        wr_wake  = wr_now && ph_addr == ADDR_WAKE_CTL;
    wire        wr_core  = wr_now && ph_addr == ADDR_CORE_CTL;
    wire        wr_stat  = wr_now && ph_addr == ADDR_IRQ_STAT;
    wire        wr_mask  = wr_now && ph_addr == ADDR_IRQ_MASK;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------
    // Pin function selection
    // ------------------------------------------------------------
    wire flash_mode = core_ctl[CORE_FLASH_BIT];
    wire fifo_mode  = interface_cfg == IFMODE_SLAVE_FIFO;
    wire wake_level = wake_ctl[WAKE_POL_BIT];
    wire pa3_wake   = wake_ctl[WAKE_PA3FN_BIT]
                      && !porta_output_enable[OE_PA3_BIT];
    wire wake2_en   = pa3_wake && wake_ctl[WAKE_EN2_BIT];
    wire wake1_act  = resume_pin == wake_level;
    wire wake2_act  = wake2_en && (pin_q[3] == wake_level);
    wire wake2_edge = wake2_en && (pin_q[3] != pa3_q);

    // Flash role overrides the port registers on its pins
    logic [5:0] next_out;
    logic [5:0] next_oe;
    always_comb begin
        next_out = port_out_reg;
        next_oe  = porta_output_enable;
        if (porta_function_cfg[0]) next_oe[0] = 1'b0;
        if (porta_function_cfg[1]) next_oe[1] = 1'b0;
        if (fifo_mode) begin
            next_oe[2] = 1'b0;
            next_oe[4] = 1'b0;
            next_oe[5] = 1'b0;
        end
        if (pa3_wake) next_oe[3] = 1'b0;
        if (flash_mode) begin
            next_out = {1'b0, !flash_protect, !chip_activity,
                        !data_activity, flash_addr_latch,
                        flash_cmd_latch};
            next_oe  = 6'h1f;
        end
    end

    // ------------------------------------------------------------
    // Pin sampling and state
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_q     <= OE_RESET;
            pa3_q     <= 1'b0;
            porta_out <= OE_RESET;
            porta_oe  <= OE_RESET;
        end else begin
            pin_q     <= porta_in;
            pa3_q     <= pin_q[3];
            porta_out <= next_out;
            porta_oe  <= next_oe;
        end
    end

    // Interrupt inputs: edge mode is falling edge, level mode follows low
    logic ext_a_prev;
    logic ext_b_prev;
    wire a_in  = porta_function_cfg[0] ? pin_q[0] : 1'b1;
    wire b_in  = porta_function_cfg[1] ? pin_q[1] : 1'b1;
    wire a_evt = core_ctl[CORE_IT0_BIT] ? (ext_a_prev && !a_in)
                                        : !a_in;
    wire b_evt = core_ctl[CORE_IT1_BIT] ? (ext_b_prev && !b_in)
                                        : !b_in;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_a_prev <= 1'b1;
            ext_b_prev <= 1'b1;
            ext_irq_a  <= 1'b0;
            ext_irq_b  <= 1'b0;
        end else begin
            ext_a_prev <= a_in;
            ext_b_prev <= b_in;
            ext_irq_a  <= a_evt;
            ext_irq_b  <= b_evt;
        end
    end

    assign fifo_output_enable_in = fifo_mode &&
        (pin_q[2] == fifo_pin_polarity[FIFO_OE_POL_BIT]);
    assign fifo_select = fifo_mode ? pin_q[5:4] : 2'h0;
    assign write_protect_switch_n = flash_mode ? pin_q[5] : 1'b1;

    // Suspend request refused while any resume source is asserted
    wire susp_req = wr_core && hwdata[CORE_SUSP_BIT];
    wire resume   = (power == PAMW_SUSPENDED) &&
                    (wake1_act || wake2_edge);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power <= PAMW_RUN;
        end else if (resume) begin
            power <= PAMW_RUN;
        end else if (susp_req && !wake1_act && !wake2_act) begin
            power <= PAMW_SUSPENDED;
        end
    end
    assign suspended = power == PAMW_SUSPENDED;
    assign osc_run   = power == PAMW_RUN;

    // ------------------------------------------------------------
    // Interrupt status, set wins over write-one-to-clear
    // ------------------------------------------------------------
    logic [IRQ_NUM-1:0] evt;
    assign evt[IRQ_WAKE1] = resume && wake1_act;
    assign evt[IRQ_WAKE2] = resume && wake2_edge;
    assign evt[IRQ_EXTA]  = a_evt && !ext_irq_a;
    assign evt[IRQ_EXTB]  = b_evt && !ext_irq_b;
    wire [IRQ_NUM-1:0] clr = wr_stat ? hwdata[IRQ_NUM-1:0] : '0;
    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // Register writes and read data
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr               <= 1'b0;
            ph_addr             <= BYTE_RESET;
            port_out_reg        <= OE_RESET;
            porta_output_enable <= OE_RESET;
            porta_function_cfg  <= 2'h0;
            interface_cfg       <= 2'h0;
            fifo_pin_polarity   <= BYTE_RESET;
            wake_ctl            <= BYTE_RESET;
            core_ctl            <= 4'h0;
            irq_stat            <= '0;
            irq_mask            <= '0;
        end else begin
            ph_wr   <= ap_valid && hwrite;
            ph_addr <= ap_valid ? haddr : ph_addr;
            if (wr_out)  port_out_reg        <= hwdata[5:0];
            if (wr_oe)   porta_output_enable <= hwdata[5:0];
            if (wr_func) porta_function_cfg  <= hwdata[1:0];
            if (wr_if)   interface_cfg       <= hwdata[1:0];
            if (wr_pol)  fifo_pin_polarity   <= hwdata[7:0];
            if (wr_wake) wake_ctl            <= hwdata[7:0];
            if (wr_core) core_ctl            <= {1'b0, hwdata[2:0]};
            if (wr_mask) irq_mask            <= hwdata[IRQ_NUM-1:0];
            irq_stat <= (irq_stat & ~clr) | evt;
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        unique case (haddr)
            ADDR_PORT_OUT: rd_mux = {26'h0, port_out_reg};
            ADDR_PORT_OE:  rd_mux = {26'h0, porta_output_enable};
            ADDR_PORT_IN:  rd_mux = {26'h0, pin_q};
            ADDR_FUNC_CFG: rd_mux = {30'h0, porta_function_cfg};
            ADDR_IF_CFG:   rd_mux = {30'h0, interface_cfg};
            ADDR_FIFO_POL: rd_mux = {24'h0, fifo_pin_polarity};
            ADDR_WAKE_CTL: rd_mux = {24'h0, wake_ctl};
            ADDR_CORE_CTL: rd_mux = {28'h0, core_ctl};
            ADDR_IRQ_STAT: rd_mux = {28'h0, irq_stat};
            ADDR_IRQ_MASK: rd_mux = {28'h0, irq_mask};
            ADDR_STATUS:   rd_mux = {30'h0, fifo_select[0] ^ 1'b0,
                                     suspended};
            default:       rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= 32'h0;
        else if (ap_valid && !hwrite) hrdata <= rd_mux;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_wake_resume: assert property (@(posedge hclk) disable iff (!hresetn)
        suspended && wake1_act |=> !suspended)
        else $error("resume pin did not leave suspend");
    a_suspend_refused: assert property (@(posedge hclk)
        disable iff (!hresetn)
        !suspended && wake1_act |=> !suspended)
        else $error("suspend entered with resume asserted");
    a_wake2_block: assert property (@(posedge hclk) disable iff (!hresetn)
        !suspended && wake2_act |=> !suspended)
        else $error("suspend entered with pin 3 asserted");
    a_irq_a_level: assert property (@(posedge hclk) disable iff (!hresetn)
        porta_function_cfg[0] && !core_ctl[CORE_IT0_BIT] && !pin_q[0]
        |=> ext_irq_a)
        else $error("level irq a missing");
    a_irq_b_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        core_ctl[CORE_IT1_BIT] && !ext_b_prev |=> !ext_irq_b)
        else $error("edge irq b repeated");
    a_pin0_input: assert property (@(posedge hclk) disable iff (!hresetn)
        porta_function_cfg[0] && !flash_mode |=> !porta_oe[0])
        else $error("irq pin driven");
    a_fifo_pins_in: assert property (@(posedge hclk) disable iff (!hresetn)
        fifo_mode && !flash_mode |=> porta_oe[5:4] == 2'h0
        && !porta_oe[2])
        else $error("fifo pins driven");
    a_flash_wp: assert property (@(posedge hclk) disable iff (!hresetn)
        flash_mode |=> porta_oe[4] && porta_out[4] == !$past(flash_protect))
        else $error("write protect wrong");
    a_flash_lamps: assert property (@(posedge hclk) disable iff (!hresetn)
        flash_mode |=> porta_out[3:2] ==
        {!$past(chip_activity), !$past(data_activity)})
        else $error("lamp drive wrong");
    c_suspend: cover property (@(posedge hclk) disable iff (!hresetn)
        suspended ##1 !suspended);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
    c_fifo: cover property (@(posedge hclk) disable iff (!hresetn)
        fifo_output_enable_in);
endmodule

/* File: verification/pamw_far_side.sv */
// Far-side model: resume sources, FIFO master, flash switch, port A pins
module pamw_far_side (
    input  wire logic [5:0] porta_out,
    input  wire logic [5:0] porta_oe,
    input  wire logic [3:0] low_drive,
    input  wire logic       fifo_mode,
    input  wire logic [1:0] fifo_addr,
    input  wire logic       wp_switch_n,
    input  wire logic       wake_level,
    output logic            resume_pin,
    output logic      [5:0] porta_in
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    logic [5:0] ext;

    assign ext[3:0]   = low_drive;
    assign ext[4]     = fifo_mode ? fifo_addr[0] : 1'b1;
    assign ext[5]     = fifo_mode ? fifo_addr[1] : wp_switch_n;
    assign resume_pin = wake_level;
    // Device drive wins wherever its enable is high
    assign porta_in   = (porta_oe & porta_out) | (~porta_oe & ext);
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the port A pin mux and wakeup block
module testbench
    import pamw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, resume_pin;
    logic [7:0]  haddr;
    logic [1:0]  htrans, fifo_select, fifo_addr;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [5:0]  porta_in, porta_out, porta_oe;
    logic [3:0]  low_drive;
    logic        flash_cmd_latch, flash_addr_latch, data_activity;
    logic        chip_activity, flash_protect, write_protect_switch_n;
    logic        fifo_output_enable_in, osc_run, suspended, irq;
    logic        ext_irq_a, ext_irq_b, fifo_mode, wp_switch_n, wake_level;
    int          bad_count = 0;
    int          samples_checked = 0;

    pamw_top dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .resume_pin,
        .porta_in, .porta_out, .porta_oe, .flash_cmd_latch,
        .flash_addr_latch, .data_activity, .chip_activity, .flash_protect,
        .write_protect_switch_n, .fifo_output_enable_in, .fifo_select,
        .osc_run, .suspended, .ext_irq_a, .ext_irq_b, .irq
    );

    pamw_far_side far_u (
        .porta_out, .porta_oe, .low_drive, .fifo_mode, .fifo_addr,
        .wp_switch_n, .wake_level, .resume_pin, .porta_in
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, a, wr, 3'h2};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic drive_wake(input int src, input logic lvl);
        if (src != 0) begin
            low_drive[3] <= lvl;
        end else begin
            wake_level <= lvl;
        end
    endtask

    task automatic report_and_stop;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic reset_test;
        check("pin_oe", 32'(porta_oe), 32'h0);
        check("levels", 32'({osc_run, suspended, irq, write_protect_switch_n,
              ext_irq_a, ext_irq_b, fifo_output_enable_in}), 32'h48);
        check("bus_resp", 32'({hreadyout, hresp}), 32'h2);
        bus(1'b0, ADDR_FUNC_CFG, 32'h0, rd);
        check("func_cfg", rd, 32'h0);
        bus(1'b0, 8'h3c, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        bus(1'b1, ADDR_PORT_OUT, 32'h15, rd);
        bus(1'b1, ADDR_PORT_OE, 32'h3f, rd);
        cyc(3);
        check("port_drive", 32'({porta_oe, porta_out}), 32'hfd5);
        bus(1'b0, ADDR_PORT_IN, 32'h0, rd);
        check("port_in", 32'(rd[5:0]), 32'h15);
        bus(1'b1, ADDR_PORT_OE, 32'h0, rd);
    endtask

    task automatic fifo_test;
        fifo_mode <= 1'b1;
        fifo_addr <= 2'h2;
        bus(1'b1, ADDR_IF_CFG, 32'(IFMODE_SLAVE_FIFO), rd);
        bus(1'b1, ADDR_FIFO_POL, 32'h1 << FIFO_OE_POL_BIT, rd);
        cyc(3);
        check("fifo_oe_hi", 32'(fifo_output_enable_in), 32'h1);
        check("fifo_sel", 32'(fifo_select), 32'h2);
        fifo_addr <= 2'h1;
        bus(1'b1, ADDR_FIFO_POL, 32'h0, rd);
        cyc(3);
        check("fifo_oe_lo", 32'(fifo_output_enable_in), 32'h0);
        check("fifo_sel", 32'(fifo_select), 32'h1);
        bus(1'b1, ADDR_IF_CFG, 32'h0, rd);
        cyc(3);
        check("fifo_off", 32'(fifo_select), 32'h0);
        fifo_mode <= 1'b0;
    endtask

    task automatic irq_test;
        int cnt;
        for (int k = 0; k < 2; k++) begin
            for (int m = 0; m < 3; m++) begin
                bus(1'b1, ADDR_FUNC_CFG, (m != 0) ? 32'(1 << k) : 32'h0, rd);
                bus(1'b1, ADDR_CORE_CTL, (m == 2) ? 32'(1 << k) : 32'h0, rd);
                low_drive[k] <= 1'b0;
                cnt = 0;
                repeat (8) begin
                    @(negedge hclk);
                    cnt += int'((k != 0 ? ext_irq_b : ext_irq_a) === 1'b1);
                end
                low_drive[k] <= 1'b1;
                check("irq_count", 32'((m == 0) ? cnt == 0 : (m == 1) ?
                      cnt > 4 : cnt == 1), 32'h1);
            end
            bus(1'b1, ADDR_IRQ_MASK, 32'hf, rd);
            bus(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
            check("irq_stat", 32'(rd[IRQ_EXTA + k]), 32'h1);
            check("irq_line", 32'(irq), 32'h1);
            bus(1'b1, ADDR_IRQ_STAT, 32'hf, rd);
            cyc(2);
            check("irq_clear", 32'(irq), 32'h0);
        end
        bus(1'b1, ADDR_FUNC_CFG, 32'h0, rd);
    endtask

    task automatic wake_test(input int src, input logic pol);
        int n;
        wake_level <= ~pol;
        low_drive[3] <= ~pol;
        bus(1'b1, ADDR_WAKE_CTL, (32'(pol) << WAKE_POL_BIT) |
            ((src != 0) ? 32'h82 : 32'h0), rd);
        drive_wake(src, pol);
        cyc(3);
        bus(1'b1, ADDR_CORE_CTL, 32'h1 << CORE_SUSP_BIT, rd);
        cyc(3);
        check("held_awake", 32'(suspended), 32'h0);
        drive_wake(src, ~pol);
        cyc(3);
        bus(1'b1, ADDR_CORE_CTL, 32'h1 << CORE_SUSP_BIT, rd);
        cyc(3);
        check("asleep", 32'({suspended, osc_run}), 32'h2);
        bus(1'b0, ADDR_STATUS, 32'h0, rd);
        check("stat_susp", 32'(rd[0]), 32'h1);
        drive_wake(src, pol);
        n = 0;
        while (osc_run !== 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        cyc(2);
        check("woken", 32'({osc_run, irq}), 32'h3);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
        check("wake_stat", 32'(rd[IRQ_WAKE1 + src]), 32'h1);
        drive_wake(src, ~pol);
        bus(1'b1, ADDR_IRQ_STAT, 32'hf, rd);
    endtask

    task automatic flash_test;
        bus(1'b1, ADDR_CORE_CTL, 32'h1 << CORE_FLASH_BIT, rd);
        for (int v = 0; v < 2; v++) begin
            {flash_cmd_latch, flash_addr_latch, data_activity, chip_activity,
             flash_protect} <= (v != 0) ? 5'h0a : 5'h15;
            wp_switch_n <= v[0];
            cyc(4);
            check("flash_oe", 32'(porta_oe), 32'h1f);
            check("flash_out", 32'(porta_out[4:0]),
                  (v != 0) ? 32'h16 : 32'h09);
            check("wp_switch", 32'(write_protect_switch_n), 32'(v));
        end
        bus(1'b1, ADDR_CORE_CTL, 32'h0, rd);
    endtask

    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        repeat (6000) @(posedge hclk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hsize, hwdata} = '0;
        {flash_cmd_latch, flash_addr_latch, data_activity, chip_activity,
         flash_protect, fifo_mode, fifo_addr, wake_level} = '0;
        {low_drive, wp_switch_n} = '1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reset_test();
        fifo_test();
        irq_test();
        wake_test(0, 1'b1);
        wake_test(0, 1'b0);
        wake_test(1, 1'b1);
        flash_test();
        report_and_stop();
    end
endmodule
